// File: rtl/cio_port_bank.sv
// bank of configurable i/o ports behind a classic wishbone slave
`timescale 1ns/100ps
`include "cio_regs.svh"

module cio_port_bank #(
  parameter int NFULL = 6,
  parameter int NARROW_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NFULL*8+NARROW_W-1:0] gpio_in_i,
  output logic [NFULL*8+NARROW_W-1:0] gpio_out_o,
  output logic [NFULL*8+NARROW_W-1:0] gpio_oe_o,
  output logic [NFULL*8+NARROW_W-1:0] gpio_pu_o,
  output logic [15:0] adc_chan_en_o,
  output logic adc_direct_en_o,
  output logic [1:0] amux_out_en_o
);

  localparam int NPORT = NFULL + 1;

  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdata_d;
  logic [15:0] ana_q;
  logic [2:0] alt_q;
  logic [15:0] chan_q;
  logic dir_q;
  logic [1:0] amux_q;
  logic req;
  logic wr_go;
  cio_pkg::cio_dec_t dec;
  logic [NPORT-1:0] cfg_we_v;
  logic [NPORT-1:0] dat_we_v;
  logic [7:0] cfg_a [NPORT];
  logic [7:0] dat_a [NPORT];
  logic [7:0] pin_a [NPORT];
  logic [7:0] ana_mask [NPORT];

  // map an address onto a port slot and register kind
  function automatic cio_pkg::cio_dec_t cio_decode(input logic [7:0] a);
    cio_pkg::cio_dec_t d;
    d.port = a[6:4];
    d.kind = cio_pkg::CIO_REG_NONE;
    if (!a[7] && (a[6:4] <= 3'(NFULL))) begin
      if (a[3:0] == `CIO_OFS_CFG) begin
        d.kind = cio_pkg::CIO_REG_CFG;
      end else if (a[3:0] == `CIO_OFS_DAT) begin
        d.kind = cio_pkg::CIO_REG_DAT;
      end else if (a[3:0] == `CIO_OFS_PIN) begin
        d.kind = cio_pkg::CIO_REG_PIN;
      end
    end
    return d;
  endfunction

  // request seen, and write committed at the edge where ack is high
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_go = req & wb_we_i & ack_q & wb_sel_i[0];
  assign dec = cio_decode(wb_adr_i);

  // per-port write strobes; only the addressed register of one port moves
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      cfg_we_v[p] = wr_go && (dec.kind == cio_pkg::CIO_REG_CFG) && (dec.port == 3'(p));
      dat_we_v[p] = wr_go && (dec.kind == cio_pkg::CIO_REG_DAT) && (dec.port == 3'(p));
    end
  end

  // analog channel enables, one bit per converter channel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ana_q <= `CIO_RST_ANA;
    end else if (req && wb_we_i && ack_q && (wb_adr_i == `CIO_ADR_ANA_EN)) begin
      if (wb_sel_i[0]) begin
        ana_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ana_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // alternate analog uses of the second analog port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alt_q <= `CIO_RST_ALT;
    end else if (wr_go && (wb_adr_i == `CIO_ADR_ALT)) begin
      alt_q <= wb_dat_i[2:0];
    end
  end

  // which pins are handed to the converter; their digital drivers go off
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      ana_mask[p] = 8'h00;
    end
    ana_mask[`CIO_PORT_ANA_LO] = ana_q[7:0];
    ana_mask[`CIO_PORT_ANA_HI] = ana_q[15:8] |
      {alt_q[`CIO_ALT_B7_DIR], alt_q[`CIO_ALT_B6_MUX], alt_q[`CIO_ALT_B5_MUX], 5'h00};
  end

  // converter side controls, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_q <= 16'h0000;
      dir_q <= 1'b0;
      amux_q <= 2'h0;
    end else begin
      chan_q <= ana_q;
      dir_q <= alt_q[`CIO_ALT_B7_DIR];
      amux_q <= {alt_q[`CIO_ALT_B6_MUX], alt_q[`CIO_ALT_B5_MUX]};
    end
  end

  assign adc_chan_en_o = chan_q;
  assign adc_direct_en_o = dir_q;
  assign amux_out_en_o = amux_q;

  // six full ports then the narrow one at the top of the pin vector
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    localparam int W = (p == NFULL) ? NARROW_W : 8;
    localparam int LSB = p * 8;
    logic [W-1:0] cfg_w;
    logic [W-1:0] dat_w;
    logic [W-1:0] pin_w;
    cio_port #(.W(W)) u_port (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg_we_i(cfg_we_v[p]),
      .dat_we_i(dat_we_v[p]),
      .wdata_i(wb_dat_i[W-1:0]),
      .ana_i(ana_mask[p][W-1:0]),
      .pad_in_i(gpio_in_i[LSB+W-1:LSB]),
      .cfg_o(cfg_w),
      .dat_o(dat_w),
      .pin_o(pin_w),
      .pad_out_o(gpio_out_o[LSB+W-1:LSB]),
      .pad_oe_o(gpio_oe_o[LSB+W-1:LSB]),
      .pad_pu_o(gpio_pu_o[LSB+W-1:LSB])
    );
    // narrow port reads zero in its missing upper bits
    assign cfg_a[p] = 8'(cfg_w);
    assign dat_a[p] = 8'(dat_w);
    assign pin_a[p] = 8'(pin_w);
  end

  // read data selection
  always_comb begin
    rdata_d = 32'h00000000;
    if (dec.kind == cio_pkg::CIO_REG_CFG) begin
      rdata_d = {24'h000000, cfg_a[dec.port]};
    end else if (dec.kind == cio_pkg::CIO_REG_DAT) begin
      rdata_d = {24'h000000, dat_a[dec.port]};
    end else if (dec.kind == cio_pkg::CIO_REG_PIN) begin
      rdata_d = {24'h000000, pin_a[dec.port]};
    end else if (wb_adr_i == `CIO_ADR_ANA_EN) begin
      rdata_d = {16'h0000, ana_q};
    end else if (wb_adr_i == `CIO_ADR_ALT) begin
      rdata_d = {29'h00000000, alt_q};
    end
  end

  // bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read data captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h00000000;
    end else if (req && !ack_q) begin
      rdat_q <= rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // helper flags for the checks below
  logic rd_narrow;
  logic rd_unmapped;
  assign rd_narrow = req && !wb_we_i && !ack_q && (dec.kind != cio_pkg::CIO_REG_NONE) &&
    (dec.port == 3'(NFULL));
  assign rd_unmapped = req && !ack_q && (dec.kind == cio_pkg::CIO_REG_NONE) &&
    (wb_adr_i != `CIO_ADR_ANA_EN) && (wb_adr_i != `CIO_ADR_ALT);

  // a fresh request is answered at the next edge
  a_ack_next_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged one cycle later");

  // ack never stands two cycles
  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // unmapped addresses answer with zero data
  a_unmapped_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_unmapped |=> (wb_ack_o && (wb_dat_o == 32'h00000000)))
    else $error("unmapped read returned data");

  // narrow port returns only its low bits
  a_narrow_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_narrow |=> (wb_dat_o[31:NARROW_W] == '0))
    else $error("narrow port read has upper bits set");

  // a write to another port leaves the first port's configuration alone
  a_other_port_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    ((|cfg_we_v) && !cfg_we_v[0]) |=> $stable(cfg_a[0]))
    else $error("config of an unaddressed port changed");

  // configuration write to port 1 lands in that port and reads back
  a_cfg_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_we_v[1] |=> (cfg_a[1] == $past(wb_dat_i[7:0])))
    else $error("config write not stored");

  // enabled channel 3 takes its pin from the digital driver one cycle later
  a_chan_low_order: assert property (@(posedge clk_i) disable iff (rst_i)
    ana_q[3] |=> (adc_chan_en_o[3] && !gpio_oe_o[3] && !gpio_pu_o[3]))
    else $error("channel 3 not routed from pin 3");

  // direct converter input frees the top pin of the second analog port
  a_direct_input_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    alt_q[`CIO_ALT_B7_DIR] |=> (adc_direct_en_o && !gpio_oe_o[15]))
    else $error("direct converter input still driven");

  // the bit-6 multiplexer output pin (pin 14) carries no digital drive or pull-up
  a_mux_out_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    alt_q[`CIO_ALT_B6_MUX] |=> (amux_out_en_o[1] && !gpio_oe_o[14] && !gpio_pu_o[14]))
    else $error("mux output pin still driven");

  // main scenarios
  c_cfg_write: cover property (@(posedge clk_i) disable iff (rst_i) |cfg_we_v);
  c_pin_read: cover property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && (dec.kind == cio_pkg::CIO_REG_PIN) ##1 wb_ack_o);
  c_push_pull_one: cover property (@(posedge clk_i) disable iff (rst_i)
    gpio_oe_o[0] && gpio_out_o[0]);
  c_analog_on: cover property (@(posedge clk_i) disable iff (rst_i) |adc_chan_en_o);

endmodule

// File: common/cio_regs.svh
// register offsets, field positions and reset values of the configurable i/o port bank
`ifndef CIO_REGS_SVH
`define CIO_REGS_SVH

// each port owns a 16-byte slot; port index sits in address bits 6:4
`define CIO_OFS_CFG 4'h0
`define CIO_OFS_DAT 4'h4
`define CIO_OFS_PIN 4'h8

// analog routing control words above the port slots
`define CIO_ADR_ANA_EN 8'h80
`define CIO_ADR_ALT 8'h84

// fields of the alternate-function word
`define CIO_ALT_B5_MUX 0
`define CIO_ALT_B6_MUX 1
`define CIO_ALT_B7_DIR 2

// port slots that carry converter channels
`define CIO_PORT_ANA_LO 0
`define CIO_PORT_ANA_HI 1

// reset values: every pin starts as a high-impedance input
`define CIO_RST_CFG 8'h00
`define CIO_RST_DAT 8'h00
`define CIO_RST_ANA 16'h0000
`define CIO_RST_ALT 3'h0

`endif

// File: common/cio_pkg.sv
// types shared by the configurable i/o port bank
package cio_pkg;

  // which register of a port slot an address selects
  typedef enum logic [1:0] {
    CIO_REG_CFG = 2'b00,
    CIO_REG_DAT = 2'b01,
    CIO_REG_PIN = 2'b10,
    CIO_REG_NONE = 2'b11
  } cio_reg_t;

  // result of decoding a bus address
  typedef struct packed {
    logic [2:0] port;
    cio_reg_t kind;
  } cio_dec_t;

endpackage

// File: rtl/cio_port.sv
// one i/o port: configuration, output data and sampled pin registers plus pad drive
`timescale 1ns/100ps
`include "cio_regs.svh"

module cio_port #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_we_i,
  input wire logic dat_we_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [W-1:0] ana_i,
  input wire logic [W-1:0] pad_in_i,
  output logic [W-1:0] cfg_o,
  output logic [W-1:0] dat_o,
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pad_out_o,
  output logic [W-1:0] pad_oe_o,
  output logic [W-1:0] pad_pu_o
);

  logic [W-1:0] cfg_q;
  logic [W-1:0] dat_q;
  logic [W-1:0] pin_q;
  logic [W-1:0] out_q;
  logic [W-1:0] oe_q;
  logic [W-1:0] pu_q;

  // configuration bits, one per pin, written as a whole byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= W'(`CIO_RST_CFG);
    end else if (cfg_we_i) begin
      cfg_q <= wdata_i;
    end
  end

  // output data bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= W'(`CIO_RST_DAT);
    end else if (dat_we_i) begin
      dat_q <= wdata_i;
    end
  end

  // pin levels sampled every cycle; analog pins read whatever the pad shows
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= '0;
    end else begin
      pin_q <= pad_in_i;
    end
  end

  // pad mode per bit from its own config, data and analog mask bits only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= '0;
      oe_q <= '0;
      pu_q <= '0;
    end else begin
      out_q <= dat_q;
      oe_q <= cfg_q & ~ana_i;
      pu_q <= ~cfg_q & dat_q & ~ana_i;
    end
  end

  assign cfg_o = cfg_q;
  assign dat_o = dat_q;
  assign pin_o = pin_q;
  assign pad_out_o = out_q;
  assign pad_oe_o = oe_q;
  assign pad_pu_o = pu_q;

  // a digital push-pull pin drives exactly its data bit
  a_push_pull_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ((pad_oe_o & pad_out_o) == ($past(cfg_q & ~ana_i) & $past(dat_q))))
    else $error("push-pull pin does not follow its data bit");

  // pull-up only on an input pin whose data bit is one, never with the driver on
  a_pull_up_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ((pad_pu_o == $past(~cfg_q & dat_q & ~ana_i)) && ((pad_pu_o & pad_oe_o) == '0)))
    else $error("weak pull-up in the wrong mode");

endmodule

// File: dv/cio_pad_model.sv
// external circuits on the port pins: hold levels on inputs, obey drive and pull-up
`timescale 1ns/100ps
module cio_pad_model #(
  parameter int N = 52
) (
  input wire logic [N-1:0] pad_out_i,
  input wire logic [N-1:0] pad_oe_i,
  input wire logic [N-1:0] pad_pu_i,
  input wire logic [N-1:0] ext_val_i,
  output logic [N-1:0] pad_o
);
  // driven pins follow the bank, pulled-up pins float high, others follow the outside
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pad_o[i] = pad_oe_i[i] ? pad_out_i[i] : (pad_pu_i[i] ? 1'b1 : ext_val_i[i]);
    end
  end
endmodule

// File: dv/config_io_port_bank_bench.sv
// self-checking bench for the configurable i/o port bank
`timescale 1ns/100ps
module config_io_port_bank_bench;
  localparam int NP = 52;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic ack;
  logic dir_en;
  logic [1:0] amux;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [NP-1:0] pin, out, oe, pu;
  logic [NP-1:0] ext = 52'h9_C3A5_6E1F_0B72;
  logic [15:0] ana_en;
  logic [15:0] am = 16'h0000;
  logic [2:0] alt = 3'h0;
  logic [7:0] cm [7];
  logic [7:0] dm [7];
  int err_count = 0;
  int checks = 0;
  int cyc_n = 0;

  // free-running clock
  initial forever #5 clk_i = ~clk_i;

  cio_port_bank dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .gpio_in_i(pin), .gpio_out_o(out), .gpio_oe_o(oe), .gpio_pu_o(pu),
    .adc_chan_en_o(ana_en), .adc_direct_en_o(dir_en), .amux_out_en_o(amux));
  cio_pad_model #(.N(NP)) pads (.pad_out_i(out), .pad_oe_i(oe), .pad_pu_i(pu),
    .ext_val_i(ext), .pad_o(pin));

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one classic wishbone cycle; read data lands in q
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1); // only the hang guard ends a lost answer
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // pin handed to the converter: channel enable, or an alternate use of bits 5 to 7
  function automatic logic is_ana(input int i);
    return (i < 16) && (am[i] || ((i > 12) && alt[i - 13]));
  endfunction

  // expected pad drive from the mirrored config, data and analog settings
  task check_pads;
    logic [NP-1:0] eo, ep, ed;
    logic c, d, an;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < NP; i++) begin
      c = cm[i/8][i%8];
      d = dm[i/8][i%8];
      an = is_ana(i);
      eo[i] = c & !an;
      ep[i] = !c & d & !an;
      ed[i] = d;
    end
    chk(oe, eo);
    chk(pu, ep);
    chk(out, ed);
  endtask

  // pin register read, analog bits masked off, missing bits expected zero
  task rd_pins(input int p);
    logic [7:0] e, m;
    int i;
    bus(1'b0, 8'(p * 16 + 8), 32'h0, 4'hF);
    for (int b = 0; b < 8; b++) begin
      i = p * 8 + b;
      m[b] = !is_ana(i);
      if (p == 6 && b > 3) begin
        e[b] = 1'b0; // missing narrow bits read zero
      end else begin
        e[b] = cm[p][b] ? dm[p][b] : (dm[p][b] | ext[i]); // driven, pulled up or outside level
      end
    end
    chk(q & {24'h0, m}, {24'h0, e & m});
  endtask

  // hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_count++;
      results;
    end
  end

  // main sequence
  initial begin
    logic [7:0] mk, c, d;
    for (int p = 0; p < 7; p++) begin
      cm[p] = 8'h00;
      dm[p] = 8'h00;
    end
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 8'h00, 32'h0, 4'hF);
    chk(q, 32'h0);
    bus(1'b0, 8'h34, 32'h0, 4'hF);
    chk(q, 32'h0);
    check_pads();
    for (int k = 0; k < 2; k++) begin
      for (int p = 0; p < 7; p++) begin
        mk = (p == 6) ? 8'h0F : 8'hFF;
        c = (8'h0F ^ 8'(p * 8'h25) ^ {8{k[0]}}) & mk;
        d = (8'h55 ^ 8'(p * 8'h13)) & mk;
        cm[p] = c;
        dm[p] = d;
        bus(1'b1, 8'(p * 16), 32'hFFFF_FF00 | 32'(c | ~mk), 4'h1);
        bus(1'b1, 8'(p * 16 + 4), 32'(d | ~mk), 4'h1);
        check_pads();
        bus(1'b0, 8'(p * 16), 32'h0, 4'hF);
        chk(q, 32'(c));
        bus(1'b0, 8'(p * 16 + 4), 32'h0, 4'hF);
        chk(q, 32'(d));
        rd_pins(p);
      end
    end
    am = 16'hA55A;
    alt = 3'h7;
    bus(1'b1, 8'h80, 32'h0000_A55A, 4'h3);
    bus(1'b1, 8'h84, 32'h0000_0007, 4'h1);
    check_pads();
    chk(ana_en, 16'hA55A);
    chk({dir_en, amux}, 3'h7);
    bus(1'b0, 8'h80, 32'h0, 4'hF);
    chk(q, 32'h0000_A55A);
    rd_pins(0);
    rd_pins(1);
    am = 16'hA5FF;
    alt = 3'h2;
    bus(1'b1, 8'h80, 32'h0000_FFFF, 4'h1);
    bus(1'b1, 8'h84, 32'h0000_0002, 4'h1);
    check_pads();
    chk(ana_en, 16'hA5FF);
    chk({dir_en, amux}, 3'h2);
    bus(1'b1, 8'h40, 32'h0000_00FF, 4'hE);
    check_pads();
    bus(1'b1, 8'h90, 32'h0000_00FF, 4'hF);
    bus(1'b0, 8'h90, 32'h0, 4'hF);
    chk(q, 32'h0);
    bus(1'b0, 8'hF8, 32'h0, 4'hF);
    chk(q, 32'h0);
    results();
  end
endmodule
